// ==== pkg/ddri_pkg.sv ====
// constants for the dual converter register front end
// assumes an 8-bit special-function register bus on the system clock
package ddri_pkg;
   // =========================================
   // widths
   localparam int unsigned code_w = 12;
   localparam int unsigned byte_w = 8;
   localparam int unsigned fmt_w = 3;
   localparam int unsigned sel_w = 3;
   // =========================================
   // register select codes
   localparam logic [2:0] sel_conv0_low = 3'h0;
   localparam logic [2:0] sel_conv0_high = 3'h1;
   localparam logic [2:0] sel_conv0_ctrl = 3'h2;
   localparam logic [2:0] sel_conv1_low = 3'h3;
   localparam logic [2:0] sel_conv1_high = 3'h4;
   localparam logic [2:0] sel_conv1_ctrl = 3'h5;
   // =========================================
   // control field layout and reset values
   localparam int unsigned enable_pos = 7;
   localparam int unsigned fmt_lsb = 0;
   localparam logic [7:0] ctrl_reset = 8'h00;
   localparam logic [7:0] data_reset = 8'h00;
   localparam logic [11:0] code_reset = 12'h000;
   localparam logic [7:0] ctrl_write_mask = 8'h87;
   localparam logic [2:0] fmt_max = 3'h4;
endpackage

// ==== rtl/ddri_channel.sv ====
// one converter channel: data bytes, control, and active code
// assumes single-cycle synchronous register writes
`timescale 1ns/10ps
module ddri_channel (
   input wire logic mclk,
   input wire logic rst,
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic wr_ctrl,
   input wire logic [7:0] wdata,
   output logic [7:0] data_low,
   output logic [7:0] data_high,
   output logic [7:0] control,
   output logic [11:0] code,
   output logic drive_en,
   output logic power_up
);
   // =========================================
   // alignment extraction
   function automatic logic [11:0] ddri_align(input logic [15:0] pair, input logic [2:0] fmt);
      logic [2:0] sh;
      sh = (fmt > ddri_pkg::fmt_max) ? ddri_pkg::fmt_max : fmt;
      return 12'((pair >> sh));
   endfunction

   // =========================================
   // data bytes
   always_ff @(posedge mclk) begin
      if (rst) begin
         data_low <= ddri_pkg::data_reset;
      end else if (wr_low) begin
         data_low <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         data_high <= ddri_pkg::data_reset;
      end else if (wr_high) begin
         data_high <= wdata;
      end
   end

   // =========================================
   // control register
   always_ff @(posedge mclk) begin
      if (rst) begin
         control <= ddri_pkg::ctrl_reset;
      end else if (wr_ctrl) begin
         control <= wdata & ddri_pkg::ctrl_write_mask;
      end
   end

   // =========================================
   // active code latched on high byte write
   always_ff @(posedge mclk) begin
      if (rst) begin
         code <= ddri_pkg::code_reset;
      end else if (wr_high) begin
         code <= ddri_align({wdata, data_low}, control[ddri_pkg::fmt_lsb +: ddri_pkg::fmt_w]);
      end
   end

   // =========================================
   // analog stage controls
   always_ff @(posedge mclk) begin
      if (rst) begin
         drive_en <= 1'h0;
         power_up <= 1'h0;
      end else begin
         drive_en <= control[ddri_pkg::enable_pos];
         power_up <= control[ddri_pkg::enable_pos];
      end
   end
endmodule

// ==== rtl/ddri_top.sv ====
// two-channel converter register front end
// assumes sel, wr_en and wdata synchronous to mclk
// one write per wr_en cycle, back-to-back writes allowed
// register map on sel:
//    0 conv0 low data byte
//    1 conv0 high data byte, loads conv0 code
//    2 conv0 control, bit 7 enable, bits 2:0 format
//    3 conv1 low data byte
//    4 conv1 high data byte, loads conv1 code
//    5 conv1 control, bit 7 enable, bits 2:0 format
//    6 and 7 unmapped, writes ignored, reads zero
// drive, power-up and bias follow their sources one clock late

`timescale 1ns/10ps
module ddri_top (
   // register bus side
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] sel,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   // reference control side
   input wire logic analog_bias_on,
   // converter zero analog side
   output logic [11:0] conv0_code,
   output logic conv0_drive_en,
   output logic conv0_power_up,
   output logic conv0_bias,
   // converter one analog side
   output logic [11:0] conv1_code,
   output logic conv1_drive_en,
   output logic conv1_power_up,
   output logic conv1_bias
);
   // =========================================
   // register contents returned to the bus
   logic [7:0] c0_low;
   logic [7:0] c0_high;
   logic [7:0] c0_ctrl;

   logic [7:0] c1_low;
   logic [7:0] c1_high;
   logic [7:0] c1_ctrl;

   logic [7:0] c0_pick;
   logic [7:0] c1_pick;
   logic [7:0] next_rdata;

   // =========================================
   // write strobes, one per register
   logic wr_c0_low;
   logic wr_c0_high;
   logic wr_c0_ctrl;

   logic wr_c1_low;
   logic wr_c1_high;
   logic wr_c1_ctrl;

   logic next_conv0_bias;
   logic next_conv1_bias;

   // =========================================
   // select decode
   function automatic logic ddri_hit(
      input logic strobe,
      input logic [2:0] addr,
      input logic [2:0] target
   );
      logic match;
      match = (addr == target);
      return strobe && match;
   endfunction

   // one channel's read value, zero unless sel is one of its codes
   function automatic logic [7:0] ddri_pick(
      input logic [2:0] addr,
      input logic [2:0] low_code,
      input logic [2:0] high_code,
      input logic [2:0] ctrl_code,
      input logic [7:0] low,
      input logic [7:0] high,
      input logic [7:0] ctrl
   );
      logic [7:0] value;
      value = ddri_pkg::data_reset;

      if (addr == low_code) begin
         value = low;
      end else if (addr == high_code) begin
         value = high;
      end else if (addr == ctrl_code) begin
         value = ctrl;
      end
      return value;
   endfunction

   // unmapped codes raise no strobe, so those writes are dropped
   always_comb begin
      wr_c0_low = ddri_hit(wr_en, sel, ddri_pkg::sel_conv0_low);
      wr_c0_high = ddri_hit(wr_en, sel, ddri_pkg::sel_conv0_high);
      wr_c0_ctrl = ddri_hit(wr_en, sel, ddri_pkg::sel_conv0_ctrl);
   end

   always_comb begin
      wr_c1_low = ddri_hit(wr_en, sel, ddri_pkg::sel_conv1_low);
      wr_c1_high = ddri_hit(wr_en, sel, ddri_pkg::sel_conv1_high);
      wr_c1_ctrl = ddri_hit(wr_en, sel, ddri_pkg::sel_conv1_ctrl);
   end

   // =========================================
   // channels
   ddri_channel u_conv0 (
      .mclk(mclk),
      .rst(rst),
      .wr_low(wr_c0_low),
      .wr_high(wr_c0_high),
      .wr_ctrl(wr_c0_ctrl),
      .wdata(wdata),
      .data_low(c0_low),
      .data_high(c0_high),
      .control(c0_ctrl),
      .code(conv0_code),
      .drive_en(conv0_drive_en),
      .power_up(conv0_power_up)
   );

   ddri_channel u_conv1 (
      .mclk(mclk),
      .rst(rst),
      .wr_low(wr_c1_low),
      .wr_high(wr_c1_high),
      .wr_ctrl(wr_c1_ctrl),
      .wdata(wdata),
      .data_low(c1_low),
      .data_high(c1_high),
      .control(c1_ctrl),
      .code(conv1_code),
      .drive_en(conv1_drive_en),
      .power_up(conv1_power_up)
   );

   // =========================================
   // bias toward analog stage, an ungated copy of analog_bias_on
   always_comb begin
      next_conv0_bias = analog_bias_on;
   end

   always_comb begin
      next_conv1_bias = analog_bias_on;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         conv0_bias <= 1'h0;
      end else begin
         conv0_bias <= next_conv0_bias;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         conv1_bias <= 1'h0;
      end else begin
         conv1_bias <= next_conv1_bias;
      end
   end

   // =========================================
   // read back
   always_comb begin
      c0_pick = ddri_pick(
         sel,
         ddri_pkg::sel_conv0_low,
         ddri_pkg::sel_conv0_high,
         ddri_pkg::sel_conv0_ctrl,
         c0_low,
         c0_high,
         c0_ctrl
      );
   end

   always_comb begin
      c1_pick = ddri_pick(
         sel,
         ddri_pkg::sel_conv1_low,
         ddri_pkg::sel_conv1_high,
         ddri_pkg::sel_conv1_ctrl,
         c1_low,
         c1_high,
         c1_ctrl
      );
   end

   // codes never overlap, so at most one pick is nonzero
   always_comb begin
      if (sel > ddri_pkg::sel_conv1_ctrl) begin
         next_rdata = ddri_pkg::data_reset;
      end else begin
         next_rdata = c0_pick | c1_pick;
      end
   end

   // registered so read data stands a full clock
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= ddri_pkg::data_reset;
      end else begin
         rdata <= next_rdata;
      end
   end
endmodule

// ==== verif/ddri_chk.sv ====
// assertions on the ports of the converter front end
// assumes one clock and a synchronous reset
`timescale 1ns/10ps
module ddri_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] sel,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic [11:0] conv0_code,
   input wire logic conv0_drive_en,
   input wire logic conv0_power_up,
   input wire logic [11:0] conv1_code,
   input wire logic conv1_drive_en,
   input wire logic conv1_power_up,
   input wire logic analog_bias_on,
   input wire logic conv0_bias,
   input wire logic conv1_bias
);
   logic [2:0] fmt0;
   logic [7:0] low0;
   always_ff @(posedge mclk) begin
      if (rst) fmt0 <= 3'h0;
      else if (wr_en && sel == 3'h2) fmt0 <= wdata[2:0];
   end
   always_ff @(posedge mclk) begin
      if (rst) low0 <= 8'h00;
      else if (wr_en && sel == 3'h0) low0 <= wdata;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_hi0;
      wr_en && sel == 3'h1;
   endsequence
   sequence s_ctl0;
      wr_en && sel == 3'h2;
   endsequence
   a_code_hold: assert property (!(wr_en && sel == 3'h1) |=> $stable(conv0_code))
      else $error("code0 moved without high write");
   a_code1_hold: assert property (!(wr_en && sel == 3'h4) |=> $stable(conv1_code))
      else $error("code1 moved without high write");
   a_code_format: assert property (s_hi0 |=> conv0_code == 12'({$past(wdata), low0}
      >> ((fmt0 > 3'h4) ? 3'h4 : fmt0))) else $error("code0 wrong alignment");
   a_enable_follow: assert property (s_ctl0 |=> ##1 conv0_drive_en == $past(wdata[7], 2))
      else $error("drive0 not following enable");
   a_enable_one: assert property (wr_en && sel == 3'h5 |-> ##2 conv1_drive_en == $past(wdata[7], 2))
      else $error("drive1 not following enable");
   a_power_drive: assert property (conv0_power_up == conv0_drive_en && conv1_power_up == conv1_drive_en)
      else $error("power and drive differ");
   a_bias_follow: assert property (!$past(rst) |-> conv0_bias == $past(analog_bias_on)
      && conv1_bias == $past(analog_bias_on)) else $error("bias not following source");
   a_unmapped_zero: assert property (sel > 3'h5 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_reset_clear: assert property (disable iff (1'b0) rst |=> conv0_code == 12'h000 && !conv0_drive_en)
      else $error("reset did not clear");
endmodule
bind ddri_top ddri_chk i_ddri_chk (.*);

// ==== verif/tb.sv ====
// self-checking bench for the converter front end
// assumes ddri_top with its checker bound
`timescale 1ns/10ps
module tb;
   logic mclk = 1'b0, rst = 1'b1, wr_en = 1'b0, bias = 1'b0;
   logic [2:0] sel = 3'h7;
   logic [7:0] wdata = 8'h00, rdata;
   logic [11:0] c0, c1;
   logic d0, p0, b0, d1, p1, b1;
   int fail_count = 0, num_checks = 0, cyc = 0;
   ddri_top i_ddri_top (.mclk(mclk), .rst(rst), .sel(sel), .wr_en(wr_en), .wdata(wdata),
      .rdata(rdata), .analog_bias_on(bias), .conv0_code(c0), .conv0_drive_en(d0),
      .conv0_power_up(p0), .conv0_bias(b0), .conv1_code(c1), .conv1_drive_en(d1),
      .conv1_power_up(p1), .conv1_bias(b1));
   initial forever #25 mclk = ~mclk;
   task automatic report_and_stop();
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic chk(string n, logic [11:0] seen, logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic wr(logic [2:0] s, logic [7:0] d);
      @(negedge mclk);
      sel = s;
      wr_en = 1'b1;
      wdata = d;
      @(negedge mclk);
      wr_en = 1'b0;
   endtask
   task automatic t_format(logic ch);
      logic [2:0] b;
      logic [11:0] e;
      b = ch ? 3'h3 : 3'h0;
      for (int f = 0; f < 8; f++) begin
         wr(b + 3'h2, {5'h10, 3'(f)});
         wr(b, 8'ha5);
         wr(b + 3'h1, 8'h3c);
         e = 12'(16'h3ca5 >> ((f > 4) ? 4 : f));
         chk("code", ch ? c1 : c0, e);
         wr(b, 8'h00);
         chk("code low only", ch ? c1 : c0, e);
         wr(b + 3'h1, 8'h5a);
         e = 12'(16'h5a00 >> ((f > 4) ? 4 : f));
         chk("code 8-bit", ch ? c1 : c0, e);
      end
      chk("drive", ch ? d1 : d0, 12'h001);
   endtask
   task automatic t_misc();
      wr(3'h2, 8'hff);
      sel = 3'h2;
      @(negedge mclk);
      chk("ctrl readback", rdata, 12'h087);
      sel = 3'h4;
      @(negedge mclk);
      chk("high readback", rdata, 12'h05a);
      sel = 3'h6;
      @(negedge mclk);
      chk("unmapped", rdata, 12'h000);
      wr(3'h2, 8'h00);
      wr(3'h5, 8'h00);
      bias = 1'b1;
      @(negedge mclk);
      chk("drive off", d0, 12'h000);
      chk("power off", p0, 12'h000);
      chk("drive1 off", d1 | p1, 12'h000);
      chk("bias", b0 & b1, 12'h001);
      bias = 1'b0;
      @(negedge mclk);
      chk("bias off", b0 | b1, 12'h000);
   endtask
   task automatic t_reset();
      repeat (8) @(negedge mclk);
      rst = 1'b0;
      chk("reset code", c0 | c1, 12'h000);
      chk("reset drive", d0 | d1, 12'h000);
   endtask
   initial begin
      t_reset();
      t_format(1'b0);
      t_format(1'b1);
      t_misc();
      report_and_stop();
   end
endmodule
